// [logic/dacc_pkg.sv]
// constants, register map and types of the dual converter control block
//
// Overview of operation
// - primary starts on software, timer two/three, pin
// - primary completion sets flag, optional interrupt
// - primary result latched into two result registers
// - software picks right or left alignment
// - window compare interrupts inside or outside range
// - primary selector: eight external plus temperature
// - external pairs single-ended or differential
// - primary gain one half to sixteen
// - primary reference: dac output or pin
// - primary shutdown under software control
// - primary starts limited to 100 ksps
// - secondary selector offers eight external channels
// - secondary gain one half to four
// - secondary starts on software, timer or pin
// - secondary may follow primary software starts
// - secondary result latched, flag, optional interrupt
// - secondary reference: analog supply or pin
// - secondary shutdown independent of primary
// - secondary starts limited to 500 ksps
// - external start routed from port pin
// - keeps running while processor is halted
package dacc_pkg;
    // register offsets
    localparam logic [7:0] PRI_CFG_OFS = 8'h00;
    localparam logic [7:0] PRI_CTL_OFS = 8'h01;
    localparam logic [7:0] PRI_DIFF_OFS = 8'h02;
    localparam logic [7:0] PRI_CMD_OFS = 8'h03;
    localparam logic [7:0] PRI_STAT_OFS = 8'h04;
    localparam logic [7:0] PRI_RES_LO_OFS = 8'h05;
    localparam logic [7:0] PRI_RES_HI_OFS = 8'h06;
    localparam logic [7:0] WIN_LO_L_OFS = 8'h07;
    localparam logic [7:0] WIN_LO_H_OFS = 8'h08;
    localparam logic [7:0] WIN_HI_L_OFS = 8'h09;
    localparam logic [7:0] WIN_HI_H_OFS = 8'h0a;
    localparam logic [7:0] SEC_CFG_OFS = 8'h10;
    localparam logic [7:0] SEC_CTL_OFS = 8'h11;
    localparam logic [7:0] SEC_CMD_OFS = 8'h12;
    localparam logic [7:0] SEC_STAT_OFS = 8'h13;
    localparam logic [7:0] SEC_RES_OFS = 8'h14;
    localparam logic [7:0] ROUTE_OFS = 8'h15;
    // reset values
    localparam logic [7:0] CFG_RST = 8'h00;
    localparam logic [15:0] WIN_HI_RST = 16'hffff;
    // field positions
    localparam int CMD_START_BIT = 0;
    localparam int CMD_CLR_DONE_BIT = 1;
    localparam int CMD_CLR_WIN_BIT = 2;
    // limits of the selector and gain codes
    localparam logic [3:0] PRI_TEMP_CHAN = 4'h8;
    localparam logic [2:0] PRI_GAIN_MAX = 3'h5;
    // timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int PRI_PERIOD_PS = 10000000;
    localparam int SEC_PERIOD_PS = 2000000;
    localparam int PRI_GAP_CYC = (PRI_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SEC_GAP_CYC = (SEC_PERIOD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // start source selects
    typedef enum logic [1:0] {
        PSRC_SW = 2'h0,
        PSRC_TMR2 = 2'h1,
        PSRC_TMR3 = 2'h2,
        PSRC_PIN = 2'h3
    } dacc_psrc_t;
    typedef enum logic [1:0] {
        SSRC_SW = 2'h0,
        SSRC_TMR = 2'h1,
        SSRC_PIN = 2'h2,
        SSRC_SYNC = 2'h3
    } dacc_ssrc_t;
    // conversion sequence, gray along idle -> conv -> done
    typedef enum logic [1:0] {
        CV_IDLE = 2'b00,
        CV_CONV = 2'b01,
        CV_DONE = 2'b11
    } dacc_cv_t;
endpackage : dacc_pkg

// [logic/dacc_ctrl.sv]
// digital control of the primary and secondary converters
`timescale 1ns/1ps
`default_nettype none
module dacc_ctrl
    import dacc_pkg::*;
#(
    parameter int RES_BITS = 12,
    parameter int PRI_GAP = PRI_GAP_CYC,
    parameter int SEC_GAP = SEC_GAP_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic tmr2_ovf,
    input wire logic tmr3_ovf,
    input wire logic sec_tmr_ovf,
    input wire logic start_pin,
    output logic pri_start,
    input wire logic pri_conv_done,
    input wire logic [RES_BITS-1:0] pri_conv_data,
    output logic [3:0] pri_chan,
    output logic [3:0] pri_diff,
    output logic [2:0] pri_gain,
    output logic pri_ref_sel,
    output logic pri_shutdown,
    output logic pri_done_irq,
    output logic pri_win_irq,
    output logic sec_start,
    input wire logic sec_conv_done,
    input wire logic [7:0] sec_conv_data,
    output logic [2:0] sec_chan,
    output logic [1:0] sec_gain,
    output logic sec_ref_sel,
    output logic sec_shutdown,
    output logic sec_done_irq
);
    // all state below runs on every clock; no stall input exists
    // so a halted processor never freezes a conversion

    // register state
    logic [7:0] pri_cfg_reg;
    logic [7:0] pri_ctl_reg;
    logic [3:0] pri_diff_reg;
    logic [15:0] win_lo_reg;
    logic [15:0] win_hi_reg;
    logic [7:0] sec_cfg_reg;
    logic [7:0] sec_ctl_reg;
    logic route_reg;
    logic [15:0] pri_res_reg;
    logic [7:0] sec_res_reg;
    logic pri_done_reg;
    logic pri_win_reg;
    logic sec_done_reg;
    logic [7:0] rdata_reg;

    // decoded control fields
    logic pri_en;
    logic pri_left;
    dacc_psrc_t pri_src;
    logic pri_win_out;
    logic pri_done_ie;
    logic pri_win_ie;
    logic sec_en;
    dacc_ssrc_t sec_src;
    logic sec_done_ie;

    assign pri_en = pri_ctl_reg[0];
    assign pri_left = pri_ctl_reg[1];
    assign pri_src = dacc_psrc_t'(pri_ctl_reg[3:2]);
    assign pri_win_out = pri_ctl_reg[4];
    assign pri_done_ie = pri_ctl_reg[5];
    assign pri_win_ie = pri_ctl_reg[6];
    assign sec_en = sec_cfg_reg[6];
    assign sec_src = dacc_ssrc_t'(sec_ctl_reg[1:0]);
    assign sec_done_ie = sec_ctl_reg[2];

    // write strobes for the command registers
    logic wr_pri_cmd;
    logic wr_sec_cmd;
    assign wr_pri_cmd = reg_wr && (reg_addr == PRI_CMD_OFS);
    assign wr_sec_cmd = reg_wr && (reg_addr == SEC_CMD_OFS);

    // start pin synchroniser, three stages
    logic pin_q1_reg;
    logic pin_q2_reg;
    logic pin_q3_reg;
    logic pin_lvl_reg;
    logic pin_rise;
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_q1_reg <= 1'b0;
            pin_q2_reg <= 1'b0;
            pin_q3_reg <= 1'b0;
        end else begin
            pin_q1_reg <= start_pin;
            pin_q2_reg <= pin_q1_reg;
            pin_q3_reg <= pin_q2_reg;
        end
    end

    // accepted level changes only when the last two stages agree
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_lvl_reg <= 1'b0;
        end else if (pin_q2_reg == pin_q3_reg) begin
            pin_lvl_reg <= pin_q3_reg;
        end
    end
    // rising edge only when routed to the pin
    assign pin_rise = route_reg && pin_q2_reg && pin_q3_reg && !pin_lvl_reg;

    // start requests per source
    logic pri_sw_go;
    logic sec_sw_go;
    logic pri_trig;
    logic sec_trig;
    assign pri_sw_go = wr_pri_cmd && reg_wdata[CMD_START_BIT];
    assign sec_sw_go = wr_sec_cmd && reg_wdata[CMD_START_BIT];

    // primary trigger select
    always_comb begin
        case (pri_src)
            PSRC_SW: pri_trig = pri_sw_go;
            PSRC_TMR2: pri_trig = tmr2_ovf;
            PSRC_TMR3: pri_trig = tmr3_ovf;
            PSRC_PIN: pri_trig = pin_rise;
            default: pri_trig = 1'b0;
        endcase
    end

    // secondary trigger select
    always_comb begin
        case (sec_src)
            SSRC_SW: sec_trig = sec_sw_go;
            SSRC_TMR: sec_trig = sec_tmr_ovf;
            SSRC_PIN: sec_trig = pin_rise;
            SSRC_SYNC: sec_trig = pri_sw_go && pri_src == PSRC_SW;
            default: sec_trig = 1'b0;
        endcase
    end

    // rate guard counters
    logic [$clog2(PRI_GAP+1)-1:0] pri_gap_reg;
    logic [$clog2(SEC_GAP+1)-1:0] sec_gap_reg;
    dacc_cv_t pri_st_reg;
    dacc_cv_t sec_st_reg;
    logic pri_go;
    logic sec_go;
    // a start is taken only when idle, powered and the rate gap expired
    assign pri_go = pri_trig && pri_en && pri_st_reg == CV_IDLE && pri_gap_reg == '0;
    assign sec_go = sec_trig && sec_en && sec_st_reg == CV_IDLE && sec_gap_reg == '0;

    // primary start spacing
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pri_gap_reg <= '0;
        end else if (pri_go) begin
            pri_gap_reg <= ($clog2(PRI_GAP+1))'(PRI_GAP - 1);
        end else if (pri_gap_reg != '0) begin
            pri_gap_reg <= pri_gap_reg - 1'b1;
        end
    end

    // secondary start spacing
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sec_gap_reg <= '0;
        end else if (sec_go) begin
            sec_gap_reg <= ($clog2(SEC_GAP+1))'(SEC_GAP - 1);
        end else if (sec_gap_reg != '0) begin
            sec_gap_reg <= sec_gap_reg - 1'b1;
        end
    end

    // primary conversion sequence
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pri_st_reg <= CV_IDLE;
        end else begin
            case (pri_st_reg)
                CV_IDLE: if (pri_go) pri_st_reg <= CV_CONV;
                CV_CONV: begin
                    if (!pri_en) pri_st_reg <= CV_IDLE;
                    else if (pri_conv_done) pri_st_reg <= CV_DONE;
                end
                CV_DONE: pri_st_reg <= CV_IDLE;
                default: pri_st_reg <= CV_IDLE;
            endcase
        end
    end

    // secondary conversion sequence
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sec_st_reg <= CV_IDLE;
        end else begin
            case (sec_st_reg)
                CV_IDLE: if (sec_go) sec_st_reg <= CV_CONV;
                CV_CONV: begin
                    if (!sec_en) sec_st_reg <= CV_IDLE;
                    else if (sec_conv_done) sec_st_reg <= CV_DONE;
                end
                CV_DONE: sec_st_reg <= CV_IDLE;
                default: sec_st_reg <= CV_IDLE;
            endcase
        end
    end

    // one-cycle start pulses to the converters
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pri_start <= 1'b0;
            sec_start <= 1'b0;
        end else begin
            pri_start <= pri_go;
            sec_start <= sec_go;
        end
    end

    // completion of a running conversion
    logic pri_fin;
    logic sec_fin;
    assign pri_fin = pri_st_reg == CV_CONV && pri_en && pri_conv_done;
    assign sec_fin = sec_st_reg == CV_CONV && sec_en && sec_conv_done;

    // justification and window test of the new primary word
    logic [15:0] pri_right;
    logic [15:0] pri_aligned;
    logic pri_inside;
    assign pri_right = 16'(pri_conv_data);
    assign pri_aligned = pri_left ? {pri_conv_data, (16-RES_BITS)'(0)} : pri_right;
    assign pri_inside = pri_right >= win_lo_reg && pri_right <= win_hi_reg;

    // result latching
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pri_res_reg <= 16'h0000;
            sec_res_reg <= 8'h00;
        end else begin
            if (pri_fin) pri_res_reg <= pri_aligned;
            if (sec_fin) sec_res_reg <= sec_conv_data;
        end
    end

    // primary completion flag, a set in the clearing cycle wins
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pri_done_reg <= 1'b0;
        end else if (pri_fin) begin
            pri_done_reg <= 1'b1;
        end else if (wr_pri_cmd && reg_wdata[CMD_CLR_DONE_BIT]) begin
            pri_done_reg <= 1'b0;
        end
    end

    // window flag, inside or outside as selected, set wins
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pri_win_reg <= 1'b0;
        end else if (pri_fin && (pri_inside != pri_win_out)) begin
            pri_win_reg <= 1'b1;
        end else if (wr_pri_cmd && reg_wdata[CMD_CLR_WIN_BIT]) begin
            pri_win_reg <= 1'b0;
        end
    end

    // secondary completion flag, a set in the clearing cycle wins
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sec_done_reg <= 1'b0;
        end else if (sec_fin) begin
            sec_done_reg <= 1'b1;
        end else if (wr_sec_cmd && reg_wdata[CMD_CLR_DONE_BIT]) begin
            sec_done_reg <= 1'b0;
        end
    end

    // interrupt requests, level while flag and enable stand
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pri_done_irq <= 1'b0;
            pri_win_irq <= 1'b0;
            sec_done_irq <= 1'b0;
        end else begin
            pri_done_irq <= pri_done_reg && pri_done_ie;
            pri_win_irq <= pri_win_reg && pri_win_ie;
            sec_done_irq <= sec_done_reg && sec_done_ie;
        end
    end

    // configuration writes
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pri_cfg_reg <= CFG_RST;
            pri_ctl_reg <= CFG_RST;
            pri_diff_reg <= 4'h0;
            win_lo_reg <= 16'h0000;
            win_hi_reg <= WIN_HI_RST;
            sec_cfg_reg <= CFG_RST;
            sec_ctl_reg <= CFG_RST;
            route_reg <= 1'b0;
        end else if (reg_wr) begin
            case (reg_addr)
                PRI_CFG_OFS: begin
                    pri_cfg_reg[3:0] <= (reg_wdata[3:0] > PRI_TEMP_CHAN) ? PRI_TEMP_CHAN : reg_wdata[3:0];
                    pri_cfg_reg[6:4] <= (reg_wdata[6:4] > PRI_GAIN_MAX) ? PRI_GAIN_MAX : reg_wdata[6:4];
                    pri_cfg_reg[7] <= reg_wdata[7];
                end
                PRI_CTL_OFS: pri_ctl_reg <= {1'b0, reg_wdata[6:0]};
                PRI_DIFF_OFS: pri_diff_reg <= reg_wdata[3:0];
                WIN_LO_L_OFS: win_lo_reg[7:0] <= reg_wdata;
                WIN_LO_H_OFS: win_lo_reg[15:8] <= reg_wdata;
                WIN_HI_L_OFS: win_hi_reg[7:0] <= reg_wdata;
                WIN_HI_H_OFS: win_hi_reg[15:8] <= reg_wdata;
                SEC_CFG_OFS: sec_cfg_reg <= {1'b0, reg_wdata[6:0]};
                SEC_CTL_OFS: sec_ctl_reg <= {5'h00, reg_wdata[2:0]};
                ROUTE_OFS: route_reg <= reg_wdata[0];
                default: ;
            endcase
        end
    end

    // analog-side control outputs
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pri_chan <= 4'h0;
            pri_diff <= 4'h0;
            pri_gain <= 3'h0;
            pri_ref_sel <= 1'b0;
            pri_shutdown <= 1'b1;
            sec_chan <= 3'h0;
            sec_gain <= 2'h0;
            sec_ref_sel <= 1'b0;
            sec_shutdown <= 1'b1;
        end else begin
            pri_chan <= pri_cfg_reg[3:0];
            pri_diff <= pri_diff_reg;
            pri_gain <= pri_cfg_reg[6:4];
            pri_ref_sel <= pri_cfg_reg[7];
            pri_shutdown <= !pri_en;
            sec_chan <= sec_cfg_reg[2:0];
            sec_gain <= sec_cfg_reg[4:3];
            sec_ref_sel <= sec_cfg_reg[5];
            sec_shutdown <= !sec_en;
        end
    end

    // read data, valid the cycle after the strobe only
    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_reg <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                PRI_CFG_OFS: rdata_reg <= pri_cfg_reg;
                PRI_CTL_OFS: rdata_reg <= pri_ctl_reg;
                PRI_DIFF_OFS: rdata_reg <= {4'h0, pri_diff_reg};
                PRI_STAT_OFS: rdata_reg <= {5'h00, pri_st_reg != CV_IDLE, pri_win_reg, pri_done_reg};
                PRI_RES_LO_OFS: rdata_reg <= pri_res_reg[7:0];
                PRI_RES_HI_OFS: rdata_reg <= pri_res_reg[15:8];
                WIN_LO_L_OFS: rdata_reg <= win_lo_reg[7:0];
                WIN_LO_H_OFS: rdata_reg <= win_lo_reg[15:8];
                WIN_HI_L_OFS: rdata_reg <= win_hi_reg[7:0];
                WIN_HI_H_OFS: rdata_reg <= win_hi_reg[15:8];
                SEC_CFG_OFS: rdata_reg <= sec_cfg_reg;
                SEC_CTL_OFS: rdata_reg <= sec_ctl_reg;
                SEC_STAT_OFS: rdata_reg <= {6'h00, sec_st_reg != CV_IDLE, sec_done_reg};
                SEC_RES_OFS: rdata_reg <= sec_res_reg;
                ROUTE_OFS: rdata_reg <= {7'h00, route_reg};
                default: rdata_reg <= 8'h00;
            endcase
        end else begin
            rdata_reg <= 8'h00;
        end
    end
    assign reg_rdata = rdata_reg;
endmodule : dacc_ctrl
`default_nettype wire

// [dv/dacc_ctrl_checker.sv]
// concurrent checks on the converter control ports
`timescale 1ns/1ps
`default_nettype none
module dacc_ctrl_checker
    import dacc_pkg::*;
#(
    parameter int PRI_GAP = PRI_GAP_CYC,
    parameter int SEC_GAP = SEC_GAP_CYC
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic pri_start,
    input wire logic sec_start,
    input wire logic [3:0] pri_chan,
    input wire logic [2:0] pri_gain,
    input wire logic pri_shutdown,
    input wire logic sec_shutdown,
    input wire logic pri_done_irq,
    input wire logic pri_win_irq,
    input wire logic sec_done_irq
);
    logic [15:0] pri_since_reg;
    logic [15:0] sec_since_reg;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // cycles since the last start of each converter, saturating
    always_ff @(posedge core_clk) begin
        if (rst || pri_start) pri_since_reg <= rst ? 16'hffff : 16'h0000;
        else if (pri_since_reg != 16'hffff) pri_since_reg <= pri_since_reg + 16'h0001;
    end
    always_ff @(posedge core_clk) begin
        if (rst || sec_start) sec_since_reg <= rst ? 16'hffff : 16'h0000;
        else if (sec_since_reg != 16'hffff) sec_since_reg <= sec_since_reg + 16'h0001;
    end
    a_reset_values: assert property (disable iff (1'b0) rst |=> pri_shutdown && sec_shutdown && !pri_start
        && !sec_start && !pri_done_irq && !pri_win_irq && !sec_done_irq && reg_rdata == 8'h00)
        else $error("outputs wrong after reset");
    a_pri_pulse: assert property (pri_start |=> !pri_start) else $error("primary start longer than one cycle");
    a_sec_pulse: assert property (sec_start |=> !sec_start) else $error("secondary start longer than one cycle");
    a_pri_rate: assert property (pri_start |-> pri_since_reg >= PRI_GAP - 1)
        else $error("primary starts too close");
    a_sec_rate: assert property (sec_start |-> sec_since_reg >= SEC_GAP - 1)
        else $error("secondary starts too close");
    a_pri_off_start: assert property (pri_start |-> !pri_shutdown)
        else $error("primary started while shut down");
    a_sec_off_start: assert property (sec_start |-> !sec_shutdown)
        else $error("secondary started while shut down");
    a_chan_range: assert property (pri_chan <= PRI_TEMP_CHAN) else $error("primary channel out of range");
    a_gain_range: assert property (pri_gain <= PRI_GAIN_MAX) else $error("primary gain out of range");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data without read");
endmodule : dacc_ctrl_checker
bind dacc_ctrl dacc_ctrl_checker #(.PRI_GAP(PRI_GAP), .SEC_GAP(SEC_GAP)) u_chk (.core_clk(core_clk), .rst(rst),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pri_start(pri_start), .sec_start(sec_start), .pri_chan(pri_chan),
    .pri_gain(pri_gain), .pri_shutdown(pri_shutdown), .sec_shutdown(sec_shutdown), .pri_done_irq(pri_done_irq),
    .pri_win_irq(pri_win_irq), .sec_done_irq(sec_done_irq));
`default_nettype wire

// [dv/tb_top.sv]
// self-checking bench of the dual converter control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import dacc_pkg::*;
    logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, sec_conv_data = 8'h00, rv;
    logic tmr2_ovf = 1'b0, tmr3_ovf = 1'b0, sec_tmr_ovf = 1'b0, start_pin = 1'b0;
    logic pri_conv_done = 1'b0, sec_conv_done = 1'b0;
    logic [11:0] pri_conv_data = 12'h000;
    logic pri_start, pri_ref_sel, pri_shutdown, pri_done_irq, pri_win_irq;
    logic sec_start, sec_ref_sel, sec_shutdown, sec_done_irq;
    logic [3:0] pri_chan, pri_diff;
    logic [2:0] pri_gain, sec_chan;
    logic [1:0] sec_gain;
    int n_mismatch = 0, tests_run = 0, cyc = 0;
    dacc_ctrl #(.RES_BITS(12), .PRI_GAP(50), .SEC_GAP(4)) u_dut (.core_clk(core_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tmr2_ovf(tmr2_ovf), .tmr3_ovf(tmr3_ovf), .sec_tmr_ovf(sec_tmr_ovf), .start_pin(start_pin),
        .pri_start(pri_start), .pri_conv_done(pri_conv_done), .pri_conv_data(pri_conv_data),
        .pri_chan(pri_chan), .pri_diff(pri_diff), .pri_gain(pri_gain), .pri_ref_sel(pri_ref_sel),
        .pri_shutdown(pri_shutdown), .pri_done_irq(pri_done_irq), .pri_win_irq(pri_win_irq),
        .sec_start(sec_start), .sec_conv_done(sec_conv_done), .sec_conv_data(sec_conv_data),
        .sec_chan(sec_chan), .sec_gain(sec_gain), .sec_ref_sel(sec_ref_sel), .sec_shutdown(sec_shutdown),
        .sec_done_irq(sec_done_irq));
    // clock and hang guard
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            results();
        end
    end
    task automatic results();
        if (n_mismatch == 0 && tests_run > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
    endtask : tick
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        rd(a, rv);
        chk({8'h00, rv}, {8'h00, exp});
    endtask : rdchk
    // one-cycle timer pulse, or pin raised until go lowers it
    task automatic trig(input int k);
        @(posedge core_clk);
        case (k)
            1: tmr2_ovf <= 1'b1;
            2: tmr3_ovf <= 1'b1;
            3: start_pin <= 1'b1;
            default: sec_tmr_ovf <= 1'b1;
        endcase
        @(posedge core_clk);
        tmr2_ovf <= 1'b0;
        tmr3_ovf <= 1'b0;
        sec_tmr_ovf <= 1'b0;
    endtask : trig
    // looks for a start pulse, then answers it with a completion
    task automatic go(input bit sec, input bit want, input logic [11:0] d);
        bit seen;
        seen = 1'b0;
        repeat (12) begin
            #1 if ((sec ? sec_start : pri_start) === 1'b1) seen = 1'b1;
            @(posedge core_clk);
        end
        chk(16'(seen), 16'(want));
        @(posedge core_clk);
        start_pin <= 1'b0;
        if (seen && sec) sec_conv_done <= 1'b1;
        if (seen && !sec) pri_conv_done <= 1'b1;
        sec_conv_data <= d[7:0];
        pri_conv_data <= d;
        @(posedge core_clk);
        pri_conv_done <= 1'b0;
        sec_conv_done <= 1'b0;
        tick(3);
    endtask : go
    // reset levels, window limit reset, unmapped read
    task automatic t_reset();
        #1 chk({pri_shutdown, sec_shutdown, pri_done_irq, pri_win_irq, sec_done_irq}, 16'h0018);
        rdchk(WIN_HI_H_OFS, 8'hff);
        rdchk(8'h20, 8'h00);
        rdchk(PRI_STAT_OFS, 8'h00);
    endtask : t_reset
    // selector, gain, reference and pair settings, clamps included
    task automatic t_cfg();
        wr(PRI_CFG_OFS, 8'hff);
        wr(PRI_DIFF_OFS, 8'h05);
        wr(SEC_CFG_OFS, 8'h7d);
        wr(PRI_CTL_OFS, 8'h61);
        tick(2);
        #1 chk({pri_chan, 1'b0, pri_gain, pri_ref_sel, pri_shutdown}, 16'h0216);
        chk(16'(pri_diff), 16'h0005);
        chk({sec_chan, sec_gain, sec_ref_sel, sec_shutdown}, 16'h005e);
    endtask : t_cfg
    // software start, flags, result, window inside, rate refusal, clear
    task automatic t_pri_sw();
        wr(WIN_LO_H_OFS, 8'h01);
        wr(WIN_HI_L_OFS, 8'h00);
        wr(WIN_HI_H_OFS, 8'h02);
        wr(PRI_CMD_OFS, 8'h01);
        go(0, 1, 12'h123);
        chk({pri_done_irq, pri_win_irq}, 16'h0003);
        tick(10);
        rdchk(PRI_STAT_OFS, 8'h03);
        rdchk(PRI_RES_LO_OFS, 8'h23);
        rdchk(PRI_RES_HI_OFS, 8'h01);
        wr(PRI_CMD_OFS, 8'h01);
        go(0, 0, 12'h000);
        wr(PRI_CMD_OFS, 8'h06);
        tick(2);
        #1 chk({pri_done_irq, pri_win_irq}, 16'h0000);
    endtask : t_pri_sw
    // left alignment with the outside-window mode, both outcomes
    task automatic t_left();
        logic [11:0] v;
        for (int i = 0; i < 2; i++) begin
            v = i ? 12'habc : 12'h123;
            tick(25);
            wr(PRI_CTL_OFS, 8'h73);
            wr(PRI_CMD_OFS, 8'h01);
            go(0, 1, v);
            chk(16'(pri_win_irq), 16'(i));
            rdchk(PRI_RES_LO_OFS, {v[3:0], 4'h0});
            rdchk(PRI_RES_HI_OFS, v[11:4]);
            wr(PRI_CMD_OFS, 8'h06);
        end
    endtask : t_left
    // timer two, timer three and routed pin, each after a wrong source
    task automatic t_sources();
        wr(ROUTE_OFS, 8'h01);
        for (int s = 1; s < 4; s++) begin
            wr(PRI_CTL_OFS, 8'(s << 2) | 8'h21);
            tick(25);
            trig(s == 1 ? 2 : 1);
            go(0, 0, 12'h000);
            trig(s);
            go(0, 1, 12'(s));
            chk(16'(pri_done_irq), 16'h0001);
            rdchk(PRI_RES_LO_OFS, 8'(s));
            wr(PRI_CMD_OFS, 8'h02);
        end
    endtask : t_sources
    // secondary in all four scheduling modes, then shut down alone
    task automatic t_sec();
        for (int s = 0; s < 4; s++) begin
            wr(SEC_CTL_OFS, 8'(s) | 8'h04);
            if (s == 3) wr(PRI_CTL_OFS, 8'h21);
            tick(25);
            if (s == 0) wr(SEC_CMD_OFS, 8'h01);
            if (s == 1) trig(4);
            if (s == 2) trig(3);
            if (s == 3) wr(PRI_CMD_OFS, 8'h01);
            go(1, 1, 12'(8'h5a + s));
            chk(16'(sec_done_irq), 16'h0001);
            rdchk(SEC_RES_OFS, 8'h5a + 8'(s));
            rdchk(SEC_STAT_OFS, 8'h01);
            wr(SEC_CMD_OFS, 8'h02);
            tick(2);
            #1 chk(16'(sec_done_irq), 16'h0000);
        end
        wr(SEC_CFG_OFS, 8'h3d);
        tick(2);
        #1 chk({sec_shutdown, pri_shutdown}, 16'h0002);
        wr(SEC_CMD_OFS, 8'h01);
        go(1, 0, 12'h000);
    endtask : t_sec
    initial begin
        tick(6);
        rst <= 1'b0;
        t_reset();
        t_cfg();
        t_pri_sw();
        t_left();
        t_sources();
        t_sec();
        results();
    end
endmodule : tb_top
`default_nettype wire
